// ===== hw/sswd_top.v
// Purpose: serial status byte builder and fail-safe frame checker
// Assumes: spi mode 0, msb first, pins sampled by core_clk_i
// Notes:   detail flags arrive as event pulses from their owners
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sswd_defines.vh"

//Contract
// - the serial-link flag rises on any main or safe serial error and clears on reset or when returned.
// - the wake flag is the OR of the five pin wake flags and the transceiver wake flag.
// - every other global flag clears on reset or once its detail flags are cleared by a read.
// - the CAN flag is the OR of the nine CAN diagnostic flags.
// - the LIN flag is the OR of the four LIN diagnostic flags.
// - the IO flag rises when a transition is recorded on a monitored IO pin.
// - the pre-regulator flag is the OR of the pre-regulator and battery events.
// - the core flag is the OR of the four core regulator events.
// - the other-supplies flag is the OR of the fifteen other regulator events.
// - inconsistent secured bits in a safe write set an error cleared only by reset.
// - a frame without exactly sixteen clocks under chip select sets the clock error.
// - an invalid safe read or write, late init write or undefined address sets the access error.
// - a safe write whose parity does not match sets the parity error.
// - each frame returns the status byte on bits fifteen down to eight.
// - a write frame must carry odd parity over all sixteen bits; the code checks this on safe writes only, main writes are not checked.
module sswd_top (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  // serial pins
  input  wire        sclk_i,
  input  wire        chip_select_low_b_i,
  input  wire        mosi_i,
  output wire        miso_o,
  // detail event sources and their read clears
  input  wire [3:0]  main_serial_err_i,
  input  wire [5:0]  wake_set_i,
  input  wire [5:0]  wake_clr_i,
  input  wire [8:0]  can_set_i,
  input  wire [8:0]  can_clr_i,
  input  wire [3:0]  lin_set_i,
  input  wire [3:0]  lin_clr_i,
  input  wire [4:0]  io_set_i,
  input  wire [4:0]  io_clr_i,
  input  wire [8:0]  prereg_set_i,
  input  wire [8:0]  prereg_clr_i,
  input  wire [3:0]  core_set_i,
  input  wire [3:0]  core_clr_i,
  input  wire [14:0] other_set_i,
  input  wire [14:0] other_clr_i,
  // avalon-mm slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // status outputs
  output wire [7:0]  global_flags_o,
  output wire [3:0]  safe_flags_o,
  output wire [15:0] rx_word_o,
  output wire        rx_strobe_o
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function odd_parity_ok;
    input [15:0] word;
    begin
      odd_parity_ok = ^word;
    end
  endfunction

  function addr_defined;
    input [4:0] addr;
    begin
      addr_defined = (addr >= `SSWD_FS_ADDR_MIN) &&
                     (addr <= `SSWD_FS_ADDR_MAX);
    end
  endfunction

  function addr_init_only;
    input [4:0] addr;
    begin
      case (addr)
        5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0C:
          addr_init_only = 1'b1;
        default:
          addr_init_only = 1'b0;
      endcase
    end
  endfunction

  // secured nibble must be the inverse of the data nibble
  function secured_ok;
    input [7:0] data;
    begin
      secured_ok = (data[3:0] == ~data[7:4]);
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [2:0] pins_sync;
  wire       sclk_s;
  wire       cs_b_s;
  wire       mosi_s;

  sswd_sync #(
    .WIDTH     (3)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    ({sclk_i, chip_select_low_b_i, mosi_i}),
    .rst_val_i  (3'h2),         // sclk idle low, cs high
    .sync_o     (pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign cs_b_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // ------------------------------------------------------------
  // detail flag groups
  // ------------------------------------------------------------
  wire wake_any;
  wire can_any;
  wire lin_any;
  wire io_any;
  wire prereg_any;
  wire core_any;
  wire other_any;

  // detail flags hold until their own read clear
  sswd_sticky #(.WIDTH(6)) u_wake (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (wake_set_i),
    .clr_i      (wake_clr_i),
    .flags_o    (),
    .any_o      (wake_any)
  );

  sswd_sticky #(.WIDTH(9)) u_can (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (can_set_i),
    .clr_i      (can_clr_i),
    .flags_o    (),
    .any_o      (can_any)
  );

  sswd_sticky #(.WIDTH(4)) u_lin (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (lin_set_i),
    .clr_i      (lin_clr_i),
    .flags_o    (),
    .any_o      (lin_any)
  );

  sswd_sticky #(.WIDTH(5)) u_io (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (io_set_i),
    .clr_i      (io_clr_i),
    .flags_o    (),
    .any_o      (io_any)
  );

  sswd_sticky #(.WIDTH(9)) u_prereg (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (prereg_set_i),
    .clr_i      (prereg_clr_i),
    .flags_o    (),
    .any_o      (prereg_any)
  );

  sswd_sticky #(.WIDTH(4)) u_core (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (core_set_i),
    .clr_i      (core_clr_i),
    .flags_o    (),
    .any_o      (core_any)
  );

  sswd_sticky #(.WIDTH(15)) u_other (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .set_i      (other_set_i),
    .clr_i      (other_clr_i),
    .flags_o    (),
    .any_o      (other_any)
  );

  // ------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------
  reg        sclk_prev_reg;
  reg        cs_b_prev_reg;
  reg [15:0] tx_reg;
  reg [15:0] tx_next;
  reg [15:0] rx_reg;
  reg [15:0] rx_next;
  reg [4:0]  cnt_reg;
  reg [4:0]  cnt_next;
  reg        miso_reg;
  reg        miso_next;
  reg [3:0]  safe_reg;
  reg [3:0]  safe_next;
  reg        serial_reg;
  reg        serial_next;
  reg [7:0]  global_reg;
  reg [15:0] last_rx_reg;
  reg [15:0] last_rx_next;
  reg        strobe_reg;
  reg        strobe_next;
  reg        init_phase_reg;
  reg [7:0]  ext_reg;

  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire [7:0] status_byte;
  wire       serial_src;
  wire [4:0] rx_addr;
  wire [7:0] rx_data;
  wire       rx_write;
  wire       rx_safe;

  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_s & sclk_prev_reg;
  assign cs_fall   = ~cs_b_s & cs_b_prev_reg;
  assign cs_rise   = cs_b_s & ~cs_b_prev_reg;

  assign rx_addr  = rx_reg[13:9];
  assign rx_data  = rx_reg[7:0];
  assign rx_write = rx_reg[`SSWD_FRM_RW];
  assign rx_safe  = rx_reg[`SSWD_FRM_TARGET];

  assign serial_src = (|main_serial_err_i) | (|safe_reg);

  // bit order fixed here; serial flag also shows a live source
  assign status_byte = {serial_reg | serial_src,
                        wake_any,
                        can_any,
                        lin_any,
                        io_any,
                        prereg_any,
                        core_any,
                        other_any};

  always @* begin
    tx_next      = tx_reg;
    rx_next      = rx_reg;
    cnt_next     = cnt_reg;
    miso_next    = miso_reg;
    safe_next    = safe_reg;
    serial_next  = serial_reg | serial_src;
    last_rx_next = last_rx_reg;
    strobe_next  = 1'b0;
    if (cs_fall) begin
      tx_next   = {status_byte, ext_reg};
      miso_next = status_byte[7];
      cnt_next  = 5'h00;
    end else if (!cs_b_s) begin
      if (sclk_rise) begin
        rx_next = {rx_reg[14:0], mosi_s};
        if (cnt_reg != 5'h1F)                    // saturate
          cnt_next = cnt_reg + 5'h01;
      end
      if (sclk_fall) begin
        tx_next   = {tx_reg[14:0], 1'b0};
        miso_next = tx_reg[14];
      end
    end
    if (cs_rise) begin
      miso_next = 1'b0;
      if (cnt_reg != `SSWD_FRAME_BITS) begin
        // pin level count error for either target
        safe_next[`SSWD_SAFE_CLOCK] = 1'b1;
      end else begin
        last_rx_next = rx_reg;
        strobe_next  = 1'b1;
        // status byte went out; a new source sets it again
        serial_next  = serial_src;
        if (rx_safe && rx_write) begin
          if (!odd_parity_ok(rx_reg))
            safe_next[`SSWD_SAFE_PARITY] = 1'b1;
          if (!secured_ok(rx_data))
            safe_next[`SSWD_SAFE_SECURED] = 1'b1;
          if (!addr_defined(rx_addr) ||
              rx_addr == `SSWD_FS_RO_A ||
              rx_addr == `SSWD_FS_RO_B ||
              (addr_init_only(rx_addr) && !init_phase_reg))
            safe_next[`SSWD_SAFE_ACCESS] = 1'b1;
        end else if (rx_safe) begin
          // reads carry zero parity and zero data
          if (!addr_defined(rx_addr) ||
              rx_reg[`SSWD_FRM_PARITY] || (|rx_data))
            safe_next[`SSWD_SAFE_ACCESS] = 1'b1;
        end
      end
    end
  end

  // safe flags have no clear besides reset
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sclk_prev_reg <= 1'b0;
      cs_b_prev_reg <= 1'b1;
      tx_reg        <= 16'h0000;
      rx_reg        <= 16'h0000;
      cnt_reg       <= 5'h00;
      miso_reg      <= 1'b0;
      safe_reg      <= 4'h0;
      serial_reg    <= 1'b0;
      global_reg    <= 8'h00;
      last_rx_reg   <= 16'h0000;
      strobe_reg    <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_b_prev_reg <= cs_b_s;
      tx_reg        <= tx_next;
      rx_reg        <= rx_next;
      cnt_reg       <= cnt_next;
      miso_reg      <= miso_next;
      safe_reg      <= safe_next;
      serial_reg    <= serial_next;
      global_reg    <= status_byte;
      last_rx_reg   <= last_rx_next;
      strobe_reg    <= strobe_next;
    end
  end

  // ------------------------------------------------------------
  // avalon-mm slave, one wait state on every access
  // ------------------------------------------------------------
  reg        wait_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  wire       req;
  wire       wr_take;

  assign req     = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ~wait_reg;

  always @* begin
    rdata_next = rdata_reg;
    if (avs_read_i && wait_reg) begin
      case (avs_address_i)
        `SSWD_OFS_CTRL:   rdata_next = {31'h0, init_phase_reg};
        `SSWD_OFS_EXT:    rdata_next = {24'h0, ext_reg};
        `SSWD_OFS_STATUS: rdata_next = {20'h0, safe_reg, global_reg};
        `SSWD_OFS_FRAME:  rdata_next = {16'h0, last_rx_reg};
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wait_reg       <= 1'b1;
      rdata_reg      <= 32'h0000_0000;
      init_phase_reg <= `SSWD_CTRL_RST;
      ext_reg        <= `SSWD_EXT_RST;
    end else begin
      // low for exactly one cycle per request
      wait_reg  <= ~(req & wait_reg);
      rdata_reg <= rdata_next;
      if (wr_take && avs_byteenable_i[0]) begin
        case (avs_address_i)
          `SSWD_OFS_CTRL: init_phase_reg <= avs_writedata_i[0];
          `SSWD_OFS_EXT:  ext_reg        <= avs_writedata_i[7:0];
          default:        ext_reg        <= ext_reg;
        endcase
      end
    end
  end

  assign miso_o            = miso_reg;
  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign global_flags_o    = global_reg;
  assign safe_flags_o      = safe_reg;
  assign rx_word_o         = last_rx_reg;
  assign rx_strobe_o       = strobe_reg;

endmodule // sswd_top

// ===== pkg/sswd_defines.vh
// Purpose: shared constants of the status word and fault checker
// Assumes: included by bare name from hw files
// Notes:   offsets are byte addresses on the register bus
`ifndef SSWD_DEFINES_VH
`define SSWD_DEFINES_VH

// register bus byte offsets
`define SSWD_OFS_CTRL      4'h0
`define SSWD_OFS_EXT       4'h4
`define SSWD_OFS_STATUS    4'h8
`define SSWD_OFS_FRAME     4'hC

// reset values
`define SSWD_CTRL_RST      1'h1
`define SSWD_EXT_RST       8'h00

// status byte bit positions (within the upper byte)
`define SSWD_BIT_SERIAL    7
`define SSWD_BIT_WAKE      6
`define SSWD_BIT_CAN       5
`define SSWD_BIT_LIN       4
`define SSWD_BIT_IO        3
`define SSWD_BIT_PREREG    2
`define SSWD_BIT_CORE      1
`define SSWD_BIT_OTHER     0

// safe error vector positions
`define SSWD_SAFE_SECURED  0
`define SSWD_SAFE_CLOCK    1
`define SSWD_SAFE_ACCESS   2
`define SSWD_SAFE_PARITY   3

// frame layout
`define SSWD_FRAME_BITS    5'h10
`define SSWD_FRM_RW        15
`define SSWD_FRM_TARGET    14
`define SSWD_FRM_PARITY    8

// fail-safe address space
`define SSWD_FS_ADDR_MIN   5'h01
`define SSWD_FS_ADDR_MAX   5'h0E
`define SSWD_FS_RO_A       5'h0D
`define SSWD_FS_RO_B       5'h0E

`endif

// ===== hw/sswd_sync.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs come from outside the core clock domain
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module sswd_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] async_i,
  input  wire [WIDTH-1:0] rst_val_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] out_reg;
  integer         i;

  // preset to the pin idle level, else a false edge follows reset
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s1_reg  <= rst_val_i;
      s2_reg  <= rst_val_i;
      s3_reg  <= rst_val_i;
      out_reg <= rst_val_i;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i])
          out_reg[i] <= s3_reg[i];
      end
    end
  end

  assign sync_o = out_reg;
endmodule // sswd_sync

// ===== hw/sswd_sticky.v
// Purpose: group of sticky detail flags with one OR summary
// Assumes: set and clear come from logic on core_clk_i
// Notes:   a set in the clear cycle wins, no event is lost
`timescale 1ns/1ps
module sswd_sticky #(
  parameter WIDTH = 4
) (
  input  wire             core_clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] set_i,
  input  wire [WIDTH-1:0] clr_i,
  output wire [WIDTH-1:0] flags_o,
  output wire             any_o
);
  reg [WIDTH-1:0] flag_reg;
  reg             any_reg;
  wire [WIDTH-1:0] flag_next;

  // set wins over clear
  assign flag_next = set_i | (flag_reg & ~clr_i);

  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      flag_reg <= {WIDTH{1'b0}};
      any_reg  <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      any_reg  <= |flag_next;
    end
  end

  assign flags_o = flag_reg;
  assign any_o   = any_reg;
endmodule // sswd_sticky

// ===== bench/sswd_top_checker.sv
// Purpose: port-level properties of the status word block
// Assumes: bound to sswd_top, one core clock domain
// Notes:   two-cycle flag lag as handed over by the designer
`timescale 1ns/1ps
module sswd_top_checker (
  input logic       core_clk_i,
  input logic       rst_b_i,
  input logic       chip_select_low_b_i,
  input logic       miso_o,
  input logic [3:0] main_serial_err_i,
  input logic [5:0] wake_set_i,
  input logic [8:0] can_set_i,
  input logic [8:0] can_clr_i,
  input logic [3:0] lin_set_i,
  input logic [3:0] core_set_i,
  input logic [7:0] global_flags_o,
  input logic [3:0] safe_flags_o,
  input logic       rx_strobe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_serial;
    |main_serial_err_i |-> ##[1:3] global_flags_o[7];
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial flag not raised");
  property p_wake;
    |wake_set_i |-> ##2 global_flags_o[6];
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake flag not raised");
  property p_can;
    |can_set_i |=> ##1 global_flags_o[5];
  endproperty
  a_can: assert property (p_can)
    else $error("can flag not raised");
  property p_lin;
    $rose(|lin_set_i) |-> ##2 global_flags_o[4];
  endproperty
  a_lin: assert property (p_lin)
    else $error("lin flag not raised");
  property p_core;
    core_set_i != 4'h0 |-> ##2 global_flags_o[1];
  endproperty
  a_core: assert property (p_core)
    else $error("core flag not raised");
  // the CAN flag may only drop two cycles after a read clear of its group
  property p_fall;
    $fell(global_flags_o[5]) |-> $past(|can_clr_i, 2);
  endproperty
  a_fall: assert property (p_fall)
    else $error("can flag dropped without a clear");
  property p_safe;
    |safe_flags_o |=>
      (safe_flags_o & $past(safe_flags_o)) == $past(safe_flags_o);
  endproperty
  a_safe: assert property (p_safe)
    else $error("safe flag dropped outside reset");
  property p_strobe;
    rx_strobe_o |-> chip_select_low_b_i ##1 !rx_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("frame strobe inside frame or too long");
  property p_idle;
    chip_select_low_b_i [*8] |-> !miso_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("serial out active while deselected");
endmodule // sswd_top_checker

bind sswd_top sswd_top_checker chk_u (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .chip_select_low_b_i(chip_select_low_b_i), .miso_o(miso_o),
  .main_serial_err_i(main_serial_err_i), .wake_set_i(wake_set_i),
  .can_set_i(can_set_i), .can_clr_i(can_clr_i),
  .lin_set_i(lin_set_i), .core_set_i(core_set_i),
  .global_flags_o(global_flags_o), .safe_flags_o(safe_flags_o),
  .rx_strobe_o(rx_strobe_o));

// ===== bench/sswd_spi_host.sv
// Purpose: serial host that sends frames and collects the reply
// Assumes: mode 0, msb first, link clock period 160 ns
// Notes:   link clock stands low between frames
`timescale 1ns/1ps
module sswd_spi_host (
  output logic sclk_o,
  output logic cs_b_o,
  output logic mosi_o,
  input  logic miso_i
);
  logic [15:0] got;
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
    got = 16'h0000;
  end
  // n other than 16 gives a deliberately broken frame
  task automatic xfer(input logic [15:0] w, input int n);
    got = 16'h0000;
    cs_b_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_o <= w[15 - i % 16];
      #80;
      sclk_o <= 1'b1;
      got = {got[14:0], miso_i};
      #80;
      sclk_o <= 1'b0;
    end
    #80;
    cs_b_o <= 1'b1;
    // released line must not keep showing the last bit
    mosi_o <= ~mosi_o;
    #100;
  endtask
endmodule // sswd_spi_host

// ===== bench/test_sswd_top.sv
// Purpose: self-checking bench for the status word block
// Assumes: register bus and serial host driven by this bench
// Notes:   safe flags clear only by reset, so each safe flag case resets first, bar secured and secured held
`timescale 1ns/1ps
`include "sswd_defines.vh"
module test_sswd_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [15:0] w;
  logic [3:0]  serr = 4'h0;
  logic [14:0] set_v [7];
  logic [14:0] clr_v [7];
  wire         sclk, cs_b, mosi, miso, wait_o, strb;
  wire  [31:0] rdat;
  wire  [7:0]  glob;
  wire  [3:0]  safe;
  wire  [15:0] rxw;
  int          bad_count = 0;
  int          tests_run = 0;
  int          strobes = 0;
  int          wid [7] = '{6, 9, 4, 5, 9, 4, 15};
  logic [7:0]  exp_row [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                               8'h02, 8'h01};
  initial foreach (set_v[i]) begin
    set_v[i] = 15'h0;
    clr_v[i] = 15'h0;
  end
  always #2.5 clk = ~clk;
  always @(posedge clk) if (strb === 1'b1) strobes++;
  sswd_top dut_u (
    .core_clk_i(clk), .rst_b_i(rst_b), .sclk_i(sclk),
    .chip_select_low_b_i(cs_b), .mosi_i(mosi), .miso_o(miso),
    .main_serial_err_i(serr),
    .wake_set_i(set_v[0][5:0]), .wake_clr_i(clr_v[0][5:0]),
    .can_set_i(set_v[1][8:0]), .can_clr_i(clr_v[1][8:0]),
    .lin_set_i(set_v[2][3:0]), .lin_clr_i(clr_v[2][3:0]),
    .io_set_i(set_v[3][4:0]), .io_clr_i(clr_v[3][4:0]),
    .prereg_set_i(set_v[4][8:0]), .prereg_clr_i(clr_v[4][8:0]),
    .core_set_i(set_v[5][3:0]), .core_clr_i(clr_v[5][3:0]),
    .other_set_i(set_v[6]), .other_clr_i(clr_v[6]),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .global_flags_o(glob), .safe_flags_o(safe),
    .rx_word_o(rxw), .rx_strobe_o(strb));
  sswd_spi_host host_u (
    .sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wn, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= wn;
    rd <= !wn;
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 40);
    if (wait_o !== 1'b0) bad_count++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pulse(input int g, input int b, input bit c);
    @(posedge clk);
    if (c) clr_v[g] <= 15'h1 << b;
    else set_v[g] <= 15'h1 << b;
    @(posedge clk);
    clr_v[g] <= 15'h0;
    set_v[g] <= 15'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [15:0] frm(input logic rw, tg,
    input logic [4:0] a, input logic [7:0] d, input logic bad);
    logic p;
    p = ~^{rw, tg, a, d} ^ bad;
    return {rw, tg, a, rw & p, d};
  endfunction

  initial begin
    do_reset;
    chk("flags", {safe, glob}, 32'h0);
    bus(1'b0, `SSWD_OFS_CTRL, 32'h0);
    chk("ctrl", q, 32'h1);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    foreach (wid[g])
      for (int b = 0; b < wid[g]; b++) begin
        pulse(g, b, 1'b0);
        chk("set", glob, exp_row[g]);
        pulse(g, b, 1'b1);
        chk("clear", glob, 8'h00);
      end
    for (int b = 0; b < 4; b++) begin
      @(posedge clk) serr <= 4'h1 << b;
      @(posedge clk) serr <= 4'h0;
      repeat (4) @(posedge clk);
      chk("serial", glob, 8'h80);
      host_u.xfer(16'h0000, 16);
      chk("reply", host_u.got, 16'h8000);
      chk("serial read", glob, 8'h00);
    end
    pulse(1, 0, 1'b0);
    pulse(5, 3, 1'b0);
    bus(1'b1, `SSWD_OFS_EXT, 32'hA5);
    w = frm(1'b1, 1'b0, 5'h15, 8'h3C, 1'b0);
    host_u.xfer(w, 16);
    chk("reply", host_u.got, 16'h22A5);
    chk("rx word", rxw, w);
    bus(1'b0, `SSWD_OFS_FRAME, 32'h0);
    chk("frame reg", q, {16'h0, w});
    bus(1'b0, `SSWD_OFS_STATUS, 32'h0);
    chk("status reg", q, 32'h022);
    do_reset;
    host_u.xfer(16'h0000, 15);
    chk("short", safe, 4'h2);
    chk("short serial", glob, 8'h80);
    chk("rx kept", rxw, 16'h0);
    do_reset;
    host_u.xfer(16'h0000, 17);
    chk("long", safe, 4'h2);
    do_reset;
    host_u.xfer(frm(1'b1, 1'b1, 5'h02, 8'h5A, 1'b0), 16);
    chk("good safe", safe, 4'h0);
    host_u.xfer(frm(1'b1, 1'b1, 5'h02, 8'h55, 1'b0), 16);
    chk("secured", safe, 4'h1);
    host_u.xfer(frm(1'b1, 1'b1, 5'h02, 8'h5A, 1'b0), 16);
    chk("secured held", safe, 4'h1);
    do_reset;
    host_u.xfer(frm(1'b1, 1'b1, 5'h02, 8'h5A, 1'b1), 16);
    chk("parity", safe, 4'h8);
    do_reset;
    bus(1'b1, `SSWD_OFS_CTRL, 32'h0);
    host_u.xfer(frm(1'b1, 1'b1, 5'h01, 8'h5A, 1'b0), 16);
    chk("late init", safe, 4'h4);
    do_reset;
    host_u.xfer(frm(1'b0, 1'b1, 5'h1F, 8'h00, 1'b0), 16);
    chk("bad addr", safe, 4'h4);
    // one strobe per frame with exactly sixteen clocks
    chk("strobes", strobes, 11);
    close_out;
  end
  // whole run needs well under 100 us
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
endmodule // test_sswd_top
